// File: rtl/can_fifo_status_event_queue.sv
// APB register block for CAN message FIFO status, event FIFO control and user address
// ----------------------------------------------------------------
// Overview of operation
// [RULE1] Transmit FIFO: empty/full flag high when nothing is queued.
// [RULE2] Receive FIFO: empty/full flag high when every slot is occupied.
// [RULE3] Transmit FIFO: half flag high while occupancy is at most half depth.
// [RULE4] Receive FIFO: half flag high while occupancy is at least half depth.
// [RULE5] Transmit FIFO: not-full flag high while a free slot exists.
// [RULE6] Receive FIFO: not-empty flag high while any message is stored.
// [RULE7] Slot index is zero based, running from zero to the size setting.
// [RULE8] Lost-arbitration and bus-error bits change only on completion, abort or reset.
// [RULE9] Aborted bit clears on status read, queue reset or send request set.
// [RULE10] Event FIFO depth is the five-bit size field plus one.
// [RULE11] Event FIFO reset bit resets the FIFO, then clears itself.
// [RULE12] Software polls the reset bit back to zero before further use.
// [RULE13] Writing one to the advance bit moves the event tail by one.
// [RULE14] Timestamp enable decides whether event entries carry a timestamp.
// [RULE15] Four event interrupt enables gate overflow, full, half and not empty.
// [RULE16] Event overflow flag sets on overflow and stays set; the code clears it on a status write with the overflow bit zero.
// [RULE17] Event full, half and not-empty flags follow occupancy, read only.
// [RULE18] Transmit FIFO user address high half gives the head address.
// [RULE19] Receive FIFO user address high half gives the tail address.
// [RULE20] Software reads user addresses only outside configuration mode.
// [RULE21] Unimplemented register bits read as zero.
// [RULE22] Direction bit one means transmit, zero means receive.
// [RULE23] Interrupt request is high while any flag meets its enable.
// ----------------------------------------------------------------
`timescale 1ns/10ps
module can_fifo_status_event_queue
  import can_fifo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tef_event_write,
  input wire logic [31:0] tef_event_time,
  output logic [31:0] tef_event_stamp,
  output logic event_timestamp_enable,
  input wire logic msg_tx_done,
  input wire logic msg_tx_lost_arb,
  input wire logic msg_tx_bus_err,
  input wire logic msg_tx_aborted,
  input wire logic msg_rx_store,
  input wire logic transmit_queue_reset,
  input wire logic [31:0] msg_ram_base,
  output logic send_request,
  output logic msg_abort_request,
  output logic fifo_irq
);
  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic rd_en;
  logic hit_tef_size;
  logic hit_tef_ctrl;
  logic hit_tef_status;
  logic hit_msg_status;
  logic hit_msg_cfg;
  logic hit_msg_ua;
  logic mapped;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en = access_ph & pwrite;
  assign rd_en = access_ph & ~pwrite;
  assign hit_tef_size = (paddr == OFF_TEF_SIZE);
  assign hit_tef_ctrl = (paddr == OFF_TEF_CTRL);
  assign hit_tef_status = (paddr == OFF_TEF_STATUS);
  assign hit_msg_status = (paddr == OFF_MSG_STATUS);
  assign hit_msg_cfg = (paddr == OFF_MSG_CFG);
  assign hit_msg_ua = (paddr == OFF_MSG_UA_HIGH);
  assign mapped = hit_tef_size | hit_tef_ctrl | hit_tef_status | hit_msg_status |
                  hit_msg_cfg | hit_msg_ua;
  // Zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;

  // ----------------------------------------------------------------
  // Event FIFO control registers
  // ----------------------------------------------------------------
  logic [4:0] tef_depth_reg;
  logic tef_reset_reg;
  logic tef_ts_en_reg;
  logic [3:0] tef_ie_reg;
  logic tef_overflow_reg;
  logic tef_advance;
  fifo_level_if tef_lv ();
  fifo_level_if msg_lv ();

  assign tef_advance = wr_en & hit_tef_ctrl & pwdata[ADVANCE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tef_depth_reg <= DEPTH_FIELD_RST;
    end else if (wr_en && hit_tef_size) begin
      tef_depth_reg <= pwdata[DEPTH_FIELD_LSB +: 5]; // [RULE10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tef_ts_en_reg <= 1'b0;
      tef_ie_reg <= IE_RST;
    end else if (wr_en && hit_tef_ctrl) begin
      tef_ts_en_reg <= pwdata[TIMESTAMP_EN_BIT];
      tef_ie_reg <= pwdata[3:0]; // [RULE15]
    end
  end

  // Reset bit stays high for exactly the cycle the tracker is cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tef_reset_reg <= 1'b0;
    end else if (tef_reset_reg) begin
      tef_reset_reg <= 1'b0; // [RULE11]
    end else if (wr_en && hit_tef_ctrl && pwdata[FIFO_RESET_BIT]) begin
      tef_reset_reg <= 1'b1; // [RULE11]
    end
  end

  // Sticky overflow: a new overflow in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tef_overflow_reg <= 1'b0;
    end else if (tef_lv.overflow) begin
      tef_overflow_reg <= 1'b1; // [RULE16]
    end else if (wr_en && hit_tef_status && !pwdata[OVERFLOW_BIT]) begin
      tef_overflow_reg <= 1'b0;
    end
  end

  assign tef_lv.push = tef_event_write;
  assign tef_lv.pop = tef_advance; // [RULE13]
  assign tef_lv.clear = tef_reset_reg; // [RULE11]
  assign tef_lv.depth_field = tef_depth_reg;

  fifo_level_tracker u_tef_level (
    .pclk(pclk),
    .presetn(presetn),
    .lv(tef_lv)
  );

  // Stamp word handed to the engine with each event entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tef_event_stamp <= 32'h0000_0000;
    end else if (tef_event_write) begin
      tef_event_stamp <= tef_ts_en_reg ? tef_event_time : 32'h0000_0000; // [RULE14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_timestamp_enable <= 1'b0;
    end else begin
      event_timestamp_enable <= tef_ts_en_reg; // [RULE14]
    end
  end

  logic [5:0] tef_depth6;
  logic [3:0] tef_flags;
  assign tef_depth6 = {1'b0, tef_depth_reg} + 6'd1;
  assign tef_flags[3] = tef_overflow_reg;
  assign tef_flags[2] = (tef_lv.count == tef_depth6); // [RULE17]
  assign tef_flags[1] = ({tef_lv.count, 1'b0} >= {1'b0, tef_depth6}); // [RULE17]
  assign tef_flags[0] = (tef_lv.count != 6'd0); // [RULE17]

  // ----------------------------------------------------------------
  // Message FIFO configuration and transmit outcome
  // ----------------------------------------------------------------
  logic msg_dir_reg;
  logic [2:0] msg_ie_reg;
  logic [4:0] msg_depth_reg;
  logic msg_reset_reg;
  logic lost_arb_reg;
  logic bus_err_reg;
  logic aborted_reg;
  logic msg_advance;
  logic send_req_set;
  logic status_read;

  assign msg_advance = wr_en & hit_msg_cfg & pwdata[ADVANCE_BIT];
  assign send_req_set = wr_en & hit_msg_cfg & pwdata[SEND_REQUEST_BIT];
  assign status_read = rd_en & hit_msg_status;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_dir_reg <= 1'b0;
      msg_ie_reg <= 3'h0;
      msg_depth_reg <= DEPTH_FIELD_RST;
    end else if (wr_en && hit_msg_cfg) begin
      msg_dir_reg <= pwdata[DIRECTION_BIT]; // [RULE22]
      msg_ie_reg <= pwdata[2:0];
      msg_depth_reg <= pwdata[MSG_DEPTH_LSB +: 5];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_reset_reg <= 1'b0;
    end else if (msg_reset_reg) begin
      msg_reset_reg <= 1'b0;
    end else if (wr_en && hit_msg_cfg && pwdata[FIFO_RESET_BIT]) begin
      msg_reset_reg <= 1'b1;
    end
  end

  // Send request drops by itself once the last queued message leaves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_request <= 1'b0;
      msg_abort_request <= 1'b0;
    end else begin
      msg_abort_request <= wr_en & hit_msg_cfg & ~pwdata[SEND_REQUEST_BIT] &
                           send_request & msg_dir_reg;
      if (send_req_set && msg_dir_reg) begin
        send_request <= 1'b1;
      end else if (wr_en && hit_msg_cfg) begin
        send_request <= 1'b0;
      end else if (msg_reset_reg || (msg_tx_done && msg_lv.count == 6'd1)) begin
        send_request <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lost_arb_reg <= 1'b0;
      bus_err_reg <= 1'b0;
    end else if (msg_reset_reg) begin
      lost_arb_reg <= 1'b0; // [RULE8]
      bus_err_reg <= 1'b0; // [RULE8]
    end else if (msg_tx_done && msg_dir_reg) begin
      lost_arb_reg <= msg_tx_lost_arb; // [RULE8]
      bus_err_reg <= msg_tx_bus_err; // [RULE8]
    end
  end

  // An abort reported in the clearing cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aborted_reg <= 1'b0;
    end else if (msg_tx_done && msg_dir_reg && msg_tx_aborted) begin
      aborted_reg <= 1'b1;
    end else if (status_read || transmit_queue_reset || send_req_set) begin
      aborted_reg <= 1'b0; // [RULE9]
    end
  end

  assign msg_lv.push = msg_dir_reg ? msg_advance : msg_rx_store; // [RULE22]
  assign msg_lv.pop = msg_dir_reg ? msg_tx_done : msg_advance; // [RULE22]
  assign msg_lv.clear = msg_reset_reg;
  assign msg_lv.depth_field = msg_depth_reg;

  fifo_level_tracker u_msg_level (
    .pclk(pclk),
    .presetn(presetn),
    .lv(msg_lv)
  );

  logic [5:0] msg_depth6;
  logic [5:0] msg_count;
  logic [2:0] msg_flags;
  logic [4:0] msg_index;
  logic [4:0] ua_index;
  logic [31:0] user_addr;

  assign msg_depth6 = {1'b0, msg_depth_reg} + 6'd1;
  assign msg_count = msg_lv.count;
  assign msg_flags[2] = msg_dir_reg ? (msg_count == 6'd0) // [RULE1]
                                    : (msg_count == msg_depth6); // [RULE2]
  assign msg_flags[1] = msg_dir_reg ? ({msg_count, 1'b0} <= {1'b0, msg_depth6}) // [RULE3]
                                    : ({msg_count, 1'b0} >= {1'b0, msg_depth6}); // [RULE4]
  assign msg_flags[0] = msg_dir_reg ? (msg_count != msg_depth6) // [RULE5]
                                    : (msg_count != 6'd0); // [RULE6]
  // Next to transmit for transmit, next to fill for receive
  assign msg_index = msg_dir_reg ? msg_lv.tail_idx : msg_lv.head_idx; // [RULE7]
  assign ua_index = msg_dir_reg ? msg_lv.head_idx : msg_lv.tail_idx; // [RULE18] [RULE19]
  assign user_addr = msg_ram_base + ({27'h000_0000, ua_index} * SLOT_BYTES);

  // ----------------------------------------------------------------
  // Read data and interrupt
  // ----------------------------------------------------------------
  logic [31:0] rdata_mux;
  always_comb begin
    rdata_mux = 32'h0000_0000; // [RULE21]
    if (hit_tef_size) begin
      rdata_mux[DEPTH_FIELD_LSB +: 5] = tef_depth_reg;
    end
    if (hit_tef_ctrl) begin
      rdata_mux[FIFO_RESET_BIT] = tef_reset_reg;
      rdata_mux[TIMESTAMP_EN_BIT] = tef_ts_en_reg;
      rdata_mux[3:0] = tef_ie_reg;
    end
    if (hit_tef_status) begin
      rdata_mux[3:0] = tef_flags;
    end
    if (hit_msg_status) begin
      rdata_mux[INDEX_LSB +: 5] = msg_index;
      rdata_mux[7:5] = {aborted_reg, lost_arb_reg, bus_err_reg};
      rdata_mux[2:0] = msg_flags;
    end
    if (hit_msg_cfg) begin
      rdata_mux[MSG_DEPTH_LSB +: 5] = msg_depth_reg;
      rdata_mux[FIFO_RESET_BIT] = msg_reset_reg;
      rdata_mux[SEND_REQUEST_BIT] = send_request;
      rdata_mux[DIRECTION_BIT] = msg_dir_reg;
      rdata_mux[2:0] = msg_ie_reg;
    end
    if (hit_msg_ua) begin
      rdata_mux[15:0] = user_addr[31:16]; // [RULE18] [RULE19]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RDATA_RST;
    end else if (setup_ph && !pwrite) begin
      prdata <= rdata_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_irq <= 1'b0;
    end else begin
      fifo_irq <= (|(tef_flags & tef_ie_reg)) | (|(msg_flags & msg_ie_reg)); // [RULE23]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tef_reset_self_clear;
    tef_reset_reg |=> !tef_reset_reg ##0 (tef_lv.count == 6'd0);
  endproperty
  a_tef_reset_self_clear: assert property (p_tef_reset_self_clear) // [RULE11]
    else $error("event FIFO reset did not clear occupancy and itself");

  property p_tef_advance_one;
    (tef_advance && !tef_event_write && !tef_reset_reg && tef_lv.count != 6'd0)
      |=> tef_lv.count == $past(tef_lv.count) - 6'd1;
  endproperty
  a_tef_advance_one: assert property (p_tef_advance_one) // [RULE13]
    else $error("event tail advance did not remove exactly one entry");

  property p_tef_overflow_sticky;
    (tef_event_write && tef_flags[2] && !tef_reset_reg)
      |=> tef_overflow_reg [*2] or (tef_overflow_reg ##1 $past(wr_en && hit_tef_status));
  endproperty
  a_tef_overflow_sticky: assert property (p_tef_overflow_sticky) // [RULE16]
    else $error("event overflow flag not set or not held");

  property p_tef_depth_limit;
    tef_lv.count <= tef_depth6;
  endproperty
  a_tef_depth_limit: assert property (p_tef_depth_limit) // [RULE10]
    else $error("event occupancy exceeds size field plus one");

  property p_rx_full_read;
    (setup_ph && !pwrite && hit_msg_status && !msg_dir_reg)
      |=> prdata[2] == ($past(msg_count) == $past(msg_depth6));
  endproperty
  a_rx_full_read: assert property (p_rx_full_read) // [RULE2]
    else $error("receive full flag read back wrong");

  property p_tx_empty_read;
    (setup_ph && !pwrite && hit_msg_status && msg_dir_reg)
      |=> prdata[2] == ($past(msg_count) == 6'd0) &&
          prdata[0] == ($past(msg_count) != $past(msg_depth6));
  endproperty
  a_tx_empty_read: assert property (p_tx_empty_read) // [RULE1]
    else $error("transmit empty or not-full flag read back wrong");

  property p_outcome_stable;
    (!msg_reset_reg && !(msg_tx_done && msg_dir_reg))
      |=> $stable(lost_arb_reg) && $stable(bus_err_reg);
  endproperty
  a_outcome_stable: assert property (p_outcome_stable) // [RULE8]
    else $error("transmit outcome bits changed outside completion or reset");

  property p_abort_clear_on_read;
    (status_read && !(msg_tx_done && msg_dir_reg && msg_tx_aborted)) |=> !aborted_reg;
  endproperty
  a_abort_clear_on_read: assert property (p_abort_clear_on_read) // [RULE9]
    else $error("aborted bit survived a status read");

  property p_irq_follows;
    ((|(tef_flags & tef_ie_reg)) || (|(msg_flags & msg_ie_reg))) |=> fifo_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // [RULE23]
    else $error("interrupt request missing for an enabled flag");

  property p_index_range;
    msg_index <= msg_depth_reg;
  endproperty
  a_index_range: assert property (p_index_range) // [RULE7]
    else $error("slot index beyond size setting");

  property p_unmapped_err;
    (access_ph && !mapped) |-> pslverr && pready;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) // [RULE21]
    else $error("unmapped access not answered with an error");

  c_tef_overflow: cover property (tef_event_write && tef_flags[2]);
  c_rx_full: cover property (!msg_dir_reg && msg_flags[2]);
  c_tx_abort: cover property (msg_tx_done && msg_dir_reg && msg_tx_aborted ##1 status_read);
  c_tef_reset: cover property (tef_flags[0] ##1 tef_reset_reg);
endmodule : can_fifo_status_event_queue

// File: rtl/can_fifo_pkg.sv
// Package: register map, field positions and sizes for the CAN FIFO status block
package can_fifo_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_TEF_SIZE = 12'h000;
  localparam logic [11:0] OFF_TEF_CTRL = 12'h004;
  localparam logic [11:0] OFF_TEF_STATUS = 12'h008;
  localparam logic [11:0] OFF_MSG_STATUS = 12'h00C;
  localparam logic [11:0] OFF_MSG_CFG = 12'h010;
  localparam logic [11:0] OFF_MSG_UA_HIGH = 12'h014;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DEPTH_FIELD_LSB = 8;
  localparam int MSG_DEPTH_LSB = 16;
  localparam int FIFO_RESET_BIT = 10;
  localparam int SEND_REQUEST_BIT = 9;
  localparam int ADVANCE_BIT = 8;
  localparam int DIRECTION_BIT = 7;
  localparam int TIMESTAMP_EN_BIT = 5;
  localparam int OVERFLOW_BIT = 3;
  localparam int INDEX_LSB = 8;
  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [4:0] DEPTH_FIELD_RST = 5'h00;
  localparam logic [3:0] IE_RST = 4'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // Bytes taken by one message slot in message RAM
  localparam logic [31:0] SLOT_BYTES = 32'h0000_0048;
endpackage : can_fifo_pkg

// File: rtl/fifo_level_if.sv
// Interface: occupancy commands and state between the register block and a level tracker
`timescale 1ns/10ps
interface fifo_level_if;
  logic push;
  logic pop;
  logic clear;
  logic [4:0] depth_field;
  logic [5:0] count;
  logic [4:0] head_idx;
  logic [4:0] tail_idx;
  logic overflow;
  modport ctrl (output push, output pop, output clear, output depth_field,
                input count, input head_idx, input tail_idx, input overflow);
  modport tracker (input push, input pop, input clear, input depth_field,
                   output count, output head_idx, output tail_idx, output overflow);
endinterface : fifo_level_if

// File: rtl/fifo_level_tracker.sv
// Occupancy counter with head and tail slot indices for one message FIFO
`timescale 1ns/10ps
module fifo_level_tracker
  import can_fifo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  fifo_level_if.tracker lv
);
  logic [5:0] depth;
  logic full;
  logic empty;
  logic do_push;
  logic do_pop;
  logic [5:0] count_reg;
  logic [4:0] head_reg;
  logic [4:0] tail_reg;

  assign depth = {1'b0, lv.depth_field} + 6'd1;
  assign full = (count_reg == depth);
  assign empty = (count_reg == 6'd0);
  // A push into a full FIFO is dropped and reported, never wraps the count
  assign do_push = lv.push & ~full;
  assign do_pop = lv.pop & ~empty;
  assign lv.overflow = lv.push & full & ~lv.clear;
  assign lv.count = count_reg;
  assign lv.head_idx = head_reg;
  assign lv.tail_idx = tail_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 6'd0;
    end else if (lv.clear) begin
      count_reg <= 6'd0;
    end else if (do_push && !do_pop) begin
      count_reg <= count_reg + 6'd1;
    end else if (do_pop && !do_push) begin
      count_reg <= count_reg - 6'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_reg <= 5'd0;
      tail_reg <= 5'd0;
    end else if (lv.clear) begin
      head_reg <= 5'd0;
      tail_reg <= 5'd0;
    end else begin
      if (do_push) begin
        head_reg <= (head_reg == lv.depth_field) ? 5'd0 : head_reg + 5'd1;
      end
      if (do_pop) begin
        tail_reg <= (tail_reg == lv.depth_field) ? 5'd0 : tail_reg + 5'd1;
      end
    end
  end
endmodule : fifo_level_tracker

// File: verif/tb.sv
// Self-checking bench for the CAN FIFO status and event queue block
`timescale 1ns/10ps
module tb;
  import can_fifo_pkg::*;
  // ----------------------------------------
  // Signals and bench state
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tef_event_write = 1'b0;
  logic [31:0] tef_event_time = 32'h0000_0000;
  logic [31:0] tef_event_stamp;
  logic event_timestamp_enable;
  logic msg_tx_done = 1'b0;
  logic msg_tx_lost_arb = 1'b0;
  logic msg_tx_bus_err = 1'b0;
  logic msg_tx_aborted = 1'b0;
  logic msg_rx_store = 1'b0;
  logic transmit_queue_reset = 1'b0;
  logic [31:0] msg_ram_base = 32'h0000_0000;
  logic send_request;
  logic msg_abort_request;
  logic fifo_irq;
  int mismatches = 0;
  int check_count = 0;
  int cnt, depth, head, tail;
  logic tx;
  logic [2:0] outc;
  logic [31:0] rd;
  logic err;

  can_fifo_status_event_queue i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tef_event_write, .tef_event_time, .tef_event_stamp, .event_timestamp_enable,
    .msg_tx_done, .msg_tx_lost_arb, .msg_tx_bus_err, .msg_tx_aborted, .msg_rx_store,
    .transmit_queue_reset, .msg_ram_base, .send_request, .msg_abort_request, .fifo_irq
  );

  always #12.5 pclk = ~pclk;

  // ----------------------------------------
  // Bus, engine and compare tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] tef_exp(input logic ovf, input int n, input int d);
    return {28'h0, ovf, n == d, 2 * n >= d, n != 0};
  endfunction : tef_exp

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Kind 0 event write, 1 transmit done, 2 receive store, 3 queue reset
  task automatic engine(input logic [1:0] kind, input logic [2:0] q);
    @(posedge pclk);
    tef_event_write <= kind == 2'h0;
    msg_tx_done <= kind == 2'h1;
    msg_rx_store <= kind == 2'h2;
    transmit_queue_reset <= kind == 2'h3;
    {msg_tx_lost_arb, msg_tx_bus_err, msg_tx_aborted} <= q;
    tef_event_time <= $urandom();
    @(posedge pclk);
    tef_event_write <= 1'b0;
    msg_tx_done <= 1'b0;
    msg_rx_store <= 1'b0;
    transmit_queue_reset <= 1'b0;
  endtask : engine

  task automatic evt_test(input logic [4:0] s, input logic ts);
    logic ovf;
    logic [31:0] t;
    depth = s + 1;
    cnt = 0;
    ovf = 1'b0;
    apb(1'b1, OFF_TEF_SIZE, {19'h0, s, 8'h0});
    apb(1'b1, OFF_TEF_CTRL, 32'h0000_0401 | {26'h0, ts, 5'h0});
    do apb(1'b0, OFF_TEF_CTRL, 32'h0); while (rd[FIFO_RESET_BIT] !== 1'b0);
    chk("tef ctrl", 32'h0000_0001 | {26'h0, ts, 5'h0}, rd);
    chk("ts enable", {31'h0, ts}, {31'h0, event_timestamp_enable});
    apb(1'b1, OFF_TEF_STATUS, 32'h0);
    apb(1'b0, OFF_TEF_SIZE, 32'h0);
    chk("tef size", {19'h0, s, 8'h0}, rd);
    for (int i = 0; i <= depth + 1; i++) begin
      if (i > 0) begin
        engine(2'h0, 3'h0);
        t = tef_event_time;
        if (cnt == depth) ovf = 1'b1;
        else cnt++;
      end
      apb(1'b0, OFF_TEF_STATUS, 32'h0);
      chk("tef status", tef_exp(ovf, cnt, depth), rd);
      chk("irq", {31'h0, cnt != 0}, {31'h0, fifo_irq});
      if (i > 0) chk("stamp", ts ? t : 32'h0, tef_event_stamp);
    end
    while (cnt > 0) begin
      apb(1'b1, OFF_TEF_CTRL, 32'h0000_0101 | {26'h0, ts, 5'h0});
      cnt--;
      apb(1'b0, OFF_TEF_STATUS, 32'h0);
      chk("tef status", tef_exp(ovf, cnt, depth), rd);
    end
  endtask : evt_test

  task automatic msg_check();
    logic [31:0] ua;
    logic [2:0] fl;
    fl = tx ? {cnt == 0, 2 * cnt <= depth, cnt < depth}
            : {cnt == depth, 2 * cnt >= depth, cnt != 0};
    ua = msg_ram_base + (tx ? head : tail) * SLOT_BYTES;
    apb(1'b0, OFF_MSG_STATUS, 32'h0);
    chk("flags", {29'h0, fl}, rd & 32'h7);
    chk("msg status", {19'h0, 5'(tx ? tail : head), outc, 2'h0, fl}, rd);
    // Outcome field is aborted, lost arbitration, bus error; the read clears aborted
    outc[2] = 1'b0;
    apb(1'b0, OFF_MSG_UA_HIGH, 32'h0);
    chk("user address", {16'h0, ua[31:16]}, rd);
    chk("irq", {31'h0, fl[0]}, {31'h0, fifo_irq});
  endtask : msg_check

  task automatic msg_test(input logic [4:0] s, input logic dir);
    logic [31:0] cfg;
    logic [2:0] q;
    tx = dir;
    depth = s + 1;
    cnt = 0;
    head = 0;
    tail = 0;
    outc = 3'h0;
    cfg = {11'h0, s, 8'h0, dir, 7'h1};
    apb(1'b1, OFF_MSG_CFG, cfg | 32'h0000_0400);
    do apb(1'b0, OFF_MSG_CFG, 32'h0); while (rd[FIFO_RESET_BIT] !== 1'b0);
    chk("msg cfg", cfg, rd);
    for (int k = 0; k <= depth; k++) begin
      if (k > 0) begin
        if (tx) apb(1'b1, OFF_MSG_CFG, cfg | 32'h0000_0100);
        else engine(2'h2, 3'($urandom()));
        cnt++;
        head = (head + 1) % depth;
      end
      msg_check();
    end
    // Send request only takes in transmit mode; dropping it there pulses an abort
    apb(1'b1, OFF_MSG_CFG, cfg | 32'h0000_0200);
    apb(1'b1, OFF_MSG_CFG, cfg);
    @(negedge pclk);
    chk("abort pulse", {31'h0, tx}, {31'h0, msg_abort_request});
    apb(1'b1, OFF_MSG_CFG, cfg | 32'h0000_0200);
    apb(1'b0, OFF_MSG_CFG, 32'h0);
    chk("send request", cfg | {22'h0, tx, 9'h0}, rd);
    while (cnt > 0) begin
      q = 3'($urandom());
      if (tx) engine(2'h1, q);
      else apb(1'b1, OFF_MSG_CFG, cfg | 32'h0000_0100);
      if (tx) outc = {q[0], q[2:1]};
      cnt--;
      tail = (tail + 1) % depth;
      // A queue reset wipes the aborted mark before software sees it
      if (tx && q[0] && cnt[0]) begin
        engine(2'h3, 3'h0);
        outc[2] = 1'b0;
      end
      msg_check();
      msg_check();
      chk("send request", {31'h0, tx && cnt != 0}, {31'h0, send_request});
    end
  endtask : msg_test

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    results();
  end

  initial begin
    void'($urandom(32'h1c070f41));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) begin
      apb(1'b0, 12'(a), 32'h0);
      chk("reset value", 32'h0, rd);
      chk("slave error", 32'h0, {31'h0, err});
    end
    // Low half near the top forces carries into the upper address half
    msg_ram_base <= $urandom() | 32'h0000_f800;
    apb(1'b1, 12'h018, $urandom());
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped read", 32'h0, rd);
    evt_test(5'h00, 1'b1);
    evt_test(5'h1f, 1'b0);
    evt_test(5'($urandom_range(1, 30)), 1'b1);
    for (int d = 0; d < 2; d++) begin
      msg_test(5'h00, d[0]);
      msg_test(5'h1f, d[0]);
      msg_test(5'($urandom_range(1, 30)), d[0]);
    end
    results();
  end
endmodule : tb
